// >>> include/plrp_defines.vh
// Constants for the per-port lamp, reset and sleep/interrupt pin logic.
`ifndef PLRP_DEFINES_VH
`define PLRP_DEFINES_VH

// ==========================================================
// Timing
// ==========================================================
// Reference clock rate in MHz and kHz.
`define PLRP_SYS_CLK_MHZ 25
`define PLRP_SYS_CLK_KHZ 25000
// Least reset low time in nanoseconds.
`define PLRP_RST_MIN_NS 1000
// Strap settle window after reset release, least time rounded up.
`define PLRP_STRAP_CYC ((`PLRP_RST_MIN_NS*`PLRP_SYS_CLK_MHZ+999)/1000)
// Half period of the activity blink in milliseconds.
`define PLRP_BLINK_HALF_MS 50
`define PLRP_BLINK_HALF_CYC (`PLRP_BLINK_HALF_MS*`PLRP_SYS_CLK_KHZ)

// ==========================================================
// Register offsets (byte addresses)
// ==========================================================
`define PLRP_ADDR_CTRL 4'h0
`define PLRP_ADDR_STATUS 4'h4
`define PLRP_ADDR_IRQ_STAT 4'h8
`define PLRP_ADDR_IRQ_MASK 4'hc

// ==========================================================
// Field positions
// ==========================================================
// Control: mode 3 select per port, duplex-in-place-of-collision
// per port, interrupt pin function per port.
`define PLRP_CTRL_MODE3 0
`define PLRP_CTRL_DUPLEX 2
`define PLRP_CTRL_IRQ_FN 4
`define PLRP_CTRL_W 6
// Status: captured mode strap, sleep request per port, link per
// port, sequence done.
`define PLRP_STAT_MODE_STRAP 0
`define PLRP_STAT_SLEEP 1
`define PLRP_STAT_LINK 3
`define PLRP_STAT_DONE 5
// Interrupt bits: three per port, port A low.
`define PLRP_IRQ_LINK 0
`define PLRP_IRQ_SPEED 1
`define PLRP_IRQ_DUPLEX 2
`define PLRP_IRQ_W 6

// ==========================================================
// Reset values
// ==========================================================
`define PLRP_CTRL_RST 6'h00
`define PLRP_IRQ_MASK_RST 6'h00

`endif

// >>> hdl/plrp_top.v
// Lamp drivers, reset sequence and sleep/interrupt pins for two ports.
`timescale 1ns/1ps
`include "plrp_defines.vh"
module plrp_top #(
  parameter BLINK_HALF_CYC = `PLRP_BLINK_HALF_CYC,
  parameter BLINK_W = 21
) (
  // Clock and reset.
  input wire I_SYS_CLK,
  input wire I_ARST_N,
  // Register port.
  input wire [3:0] I_ADDR,
  input wire [31:0] I_WDATA,
  input wire I_WR,
  input wire I_RD,
  output reg [31:0] O_RDATA,
  // Status from the transceiver core, same clock, index 0 is port A.
  input wire [1:0] I_LINK_GOOD,
  input wire [1:0] I_SPEED_100,
  input wire [1:0] I_FULL_DUPLEX,
  input wire [1:0] I_TX_ACTIVE,
  input wire [1:0] I_RX_ACTIVE,
  input wire [1:0] I_COLLISION,
  // Lamp mode strap pin.
  input wire I_LED_CFG_STRAP,
  // Port A lamp pins, each input, output and output enable.
  input wire I_PORT_A_LINK_LAMP,
  output wire O_PORT_A_LINK_LAMP,
  output wire O_PORT_A_LINK_LAMP_OE,
  input wire I_PORT_A_RATE_LAMP,
  output wire O_PORT_A_RATE_LAMP,
  output wire O_PORT_A_RATE_LAMP_OE,
  input wire I_PORT_A_TRAFFIC_LAMP,
  output wire O_PORT_A_TRAFFIC_LAMP,
  output wire O_PORT_A_TRAFFIC_LAMP_OE,
  // Port B lamp pins.
  input wire I_PORT_B_LINK_LAMP,
  output wire O_PORT_B_LINK_LAMP,
  output wire O_PORT_B_LINK_LAMP_OE,
  input wire I_PORT_B_RATE_LAMP,
  output wire O_PORT_B_RATE_LAMP,
  output wire O_PORT_B_RATE_LAMP_OE,
  input wire I_PORT_B_TRAFFIC_LAMP,
  output wire O_PORT_B_TRAFFIC_LAMP,
  output wire O_PORT_B_TRAFFIC_LAMP_OE,
  // Shared sleep / interrupt pins, open drain.
  input wire I_PORT_A_SLEEP_IRQ_PIN,
  output wire O_PORT_A_SLEEP_IRQ_PIN,
  output wire O_PORT_A_SLEEP_IRQ_PIN_OE,
  input wire I_PORT_B_SLEEP_IRQ_PIN,
  output wire O_PORT_B_SLEEP_IRQ_PIN,
  output wire O_PORT_B_SLEEP_IRQ_PIN_OE,
  // Power-down request to the core and combined interrupt.
  output reg [1:0] O_POWER_DOWN,
  output wire O_IRQ
);

  // ========================================================
  // Constants and states
  // ========================================================
  // Strap window length. The macro is a 32-bit integer, so the
  // last count is cut to the counter width on purpose.
  localparam integer STRAP_LAST_I = `PLRP_STRAP_CYC - 1;
  localparam [7:0] STRAP_LAST = STRAP_LAST_I[7:0];
  // Sequence states, one-hot.
  localparam [1:0] ST_STRAP = 2'h1;
  localparam [1:0] ST_RUN = 2'h2;

  // ========================================================
  // Pin synchronisers
  // ========================================================
  // Raw pin levels: six lamps, two shared pins, mode strap.
  wire [8:0] pin_raw;
  // First and second synchroniser stages.
  reg [8:0] pin_meta;
  reg [8:0] pin_sync;

  assign pin_raw = {I_LED_CFG_STRAP,
                    I_PORT_B_SLEEP_IRQ_PIN, I_PORT_A_SLEEP_IRQ_PIN,
                    I_PORT_B_TRAFFIC_LAMP, I_PORT_B_RATE_LAMP,
                    I_PORT_B_LINK_LAMP,
                    I_PORT_A_TRAFFIC_LAMP, I_PORT_A_RATE_LAMP,
                    I_PORT_A_LINK_LAMP};

  // Resetting to zero makes the shared pins look like a sleep request;
  // that is harmless because run stays low until real levels arrive.
  // Two flip-flops on every pin; only pin_sync is read onward.
  always @(posedge I_SYS_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      pin_meta <= 9'h000;
      pin_sync <= 9'h000;
    end else begin
      pin_meta <= pin_raw;
      pin_sync <= pin_meta;
    end
  end

  // ========================================================
  // Reset sequence and strap capture
  // ========================================================
  // Sequence state and settle counter.
  reg [1:0] state;
  reg [7:0] strap_cnt;
  // Captured lamp pulls (1 = pulled up) and mode strap.
  reg [5:0] lamp_pull;
  reg mode_strap;
  // True once straps are held and pins take their functions.
  wire run;

  assign run = state[1];

  // The async reset cannot sample a pin, so the pins are left
  // undriven for a settle window after release and the synced
  // levels are caught at its end. Every assertion of reset
  // restarts this whole sequence.
  always @(posedge I_SYS_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      state <= ST_STRAP;
      strap_cnt <= 8'h00;
      lamp_pull <= 6'h00;
      mode_strap <= 1'b0;
    end else begin
      case (state)
        ST_STRAP: begin
          if (strap_cnt == STRAP_LAST) begin
            // Catch every strap, lamps included.
            lamp_pull <= pin_sync[5:0];
            mode_strap <= pin_sync[8];
            state <= ST_RUN;
          end else begin
            strap_cnt <= strap_cnt + 8'h01;
          end
        end
        ST_RUN: begin
          state <= ST_RUN;
        end
        default: begin
          state <= ST_STRAP;
        end
      endcase
    end
  end

  // ========================================================
  // Software registers
  // ========================================================
  // Control, interrupt status and interrupt mask.
  reg [5:0] ctrl;
  reg [5:0] irq_stat;
  reg [5:0] irq_mask;
  // Events raised by the port logic this cycle.
  wire [5:0] irq_set;
  // Write strobes decoded per register.
  wire wr_ctrl;
  wire wr_istat;
  wire wr_imask;
  // Read data for the addressed register.
  reg [31:0] next_rdata;
  // Unmasked pending bits.
  wire [5:0] irq_live;

  assign wr_ctrl = I_WR && (I_ADDR == `PLRP_ADDR_CTRL);
  assign wr_istat = I_WR && (I_ADDR == `PLRP_ADDR_IRQ_STAT);
  assign wr_imask = I_WR && (I_ADDR == `PLRP_ADDR_IRQ_MASK);
  assign irq_live = irq_stat & irq_mask;
  assign O_IRQ = |irq_live;

  // Register writes; all bits go back to defaults on reset.
  // Only the low six write data bits are kept; the rest are ignored.
  always @(posedge I_SYS_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      ctrl <= `PLRP_CTRL_RST;
      irq_mask <= `PLRP_IRQ_MASK_RST;
      irq_stat <= 6'h00;
    end else begin
      if (wr_ctrl) begin
        ctrl <= I_WDATA[5:0];
      end
      if (wr_imask) begin
        irq_mask <= I_WDATA[5:0];
      end
      // Write one to clear; a new event in the same cycle wins.
      // A clear that loses to a new event leaves the bit set, so
      // software never misses that change.
      if (wr_istat) begin
        irq_stat <= (irq_stat & ~I_WDATA[5:0]) | irq_set;
      end else begin
        irq_stat <= irq_stat | irq_set;
      end
    end
  end

  // Read mux; unmapped offsets read as zero.
  always @* begin
    next_rdata = 32'h0000_0000;
    if (I_RD) begin
      case (I_ADDR)
        `PLRP_ADDR_CTRL: begin
          next_rdata = {26'h000_0000, ctrl};
        end
        `PLRP_ADDR_STATUS: begin
          next_rdata = {26'h000_0000, run, I_LINK_GOOD,
                        O_POWER_DOWN, mode_strap};
        end
        `PLRP_ADDR_IRQ_STAT: begin
          next_rdata = {26'h000_0000, irq_stat};
        end
        `PLRP_ADDR_IRQ_MASK: begin
          next_rdata = {26'h000_0000, irq_mask};
        end
        default: begin
          next_rdata = 32'h0000_0000;
        end
      endcase
    end
  end

  // Read data stands only in the cycle after the strobe.
  always @(posedge I_SYS_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      O_RDATA <= 32'h0000_0000;
    end else begin
      O_RDATA <= next_rdata;
    end
  end

  // ========================================================
  // Per-port lamp and shared pin logic
  // ========================================================
  // Lamp drive levels, three per port, port A low.
  wire [5:0] lamp_out;
  // Shared pin drive enables.
  wire [1:0] sleep_pin_oe;
  // Sleep request seen on the shared pins.
  wire [1:0] sleep_req;

  genvar p;
  generate
    for (p = 0; p < 2; p = p + 1) begin : g_port
      // Blink timebase and phase, private to this port.
      reg [BLINK_W-1:0] blink_cnt;
      reg blink_on;
      // Previous core status, for change events.
      reg link_q;
      reg speed_q;
      reg dup_q;
      // Lit levels before polarity.
      wire active;
      wire mode1;
      wire lit_link;
      wire lit_rate;
      wire lit_traffic;
      wire irq_pending;
      // Last blink count, cut to the counter width on purpose.
      localparam integer BLINK_LAST_I = BLINK_HALF_CYC - 1;
      localparam [BLINK_W-1:0] BLINK_LAST = BLINK_LAST_I[BLINK_W-1:0];

      // Each port keeps its own timebase; sharing one would save flops
      // but would tie the blink phases of the two ports together.
      // Free-running toggle gives a slow, visible blink.
      always @(posedge I_SYS_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
          blink_cnt <= {BLINK_W{1'b0}};
          blink_on <= 1'b0;
        end else if (blink_cnt == BLINK_LAST) begin
          blink_cnt <= {BLINK_W{1'b0}};
          blink_on <= ~blink_on;
        end else begin
          blink_cnt <= blink_cnt + {{(BLINK_W-1){1'b0}}, 1'b1};
        end
      end

      // Track status to raise change events.
      always @(posedge I_SYS_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
          link_q <= 1'b0;
          speed_q <= 1'b0;
          dup_q <= 1'b0;
        end else begin
          link_q <= I_LINK_GOOD[p];
          speed_q <= I_SPEED_100[p];
          dup_q <= I_FULL_DUPLEX[p];
        end
      end

      // Events count only once the sequence has finished.
      assign irq_set[3*p+`PLRP_IRQ_LINK] =
        run && (link_q != I_LINK_GOOD[p]);
      assign irq_set[3*p+`PLRP_IRQ_SPEED] =
        run && (speed_q != I_SPEED_100[p]);
      assign irq_set[3*p+`PLRP_IRQ_DUPLEX] =
        run && (dup_q != I_FULL_DUPLEX[p]);

      // Strap 1 gives mode 1; mode 3 by software overrides.
      assign active = I_TX_ACTIVE[p] | I_RX_ACTIVE[p];
      assign mode1 = mode_strap && !ctrl[`PLRP_CTRL_MODE3+p];
      // Link lamp: steady in mode 1, blinks on traffic otherwise.
      assign lit_link = mode1 ? I_LINK_GOOD[p] :
        (I_LINK_GOOD[p] && !(active && blink_on));
      // Rate lamp has no mode term at all.
      assign lit_rate = I_SPEED_100[p];
      // Traffic lamp: activity, collision, or duplex in mode 3.
      assign lit_traffic = mode1 ? active :
        ((ctrl[`PLRP_CTRL_MODE3+p] && ctrl[`PLRP_CTRL_DUPLEX+p]) ?
         I_FULL_DUPLEX[p] : I_COLLISION[p]);
      // A pin pulled up lights low, pulled down lights high.
      assign lamp_out[3*p] = lit_link ^ lamp_pull[3*p];
      assign lamp_out[3*p+1] = lit_rate ^ lamp_pull[3*p+1];
      assign lamp_out[3*p+2] = lit_traffic ^ lamp_pull[3*p+2];

      // Shared pin: in interrupt function pull low on pending interrupt, else release.
      assign irq_pending = |irq_live[3*p+2:3*p];
      assign sleep_pin_oe[p] = run && ctrl[`PLRP_CTRL_IRQ_FN+p] &&
        irq_pending;
      assign sleep_req[p] = run && !ctrl[`PLRP_CTRL_IRQ_FN+p] &&
        !pin_sync[6+p];
    end
  endgenerate

  // Limitation: leaving the interrupt function while this port still
  // pulls its pin low lets the synchroniser show that low level for
  // two more cycles, which reads as a short power-down request.
  // Software should clear pending events before switching back.
  // Power-down follows the synced pin while in sleep function.
  always @(posedge I_SYS_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      O_POWER_DOWN <= 2'h0;
    end else begin
      O_POWER_DOWN <= sleep_req;
    end
  end

  // ========================================================
  // Pin drivers
  // ========================================================
  // Lamps stay undriven during the strap window so the pulls
  // can be read; the levels themselves are combinational.
  assign O_PORT_A_LINK_LAMP = lamp_out[0];
  assign O_PORT_A_RATE_LAMP = lamp_out[1];
  assign O_PORT_A_TRAFFIC_LAMP = lamp_out[2];
  assign O_PORT_B_LINK_LAMP = lamp_out[3];
  assign O_PORT_B_RATE_LAMP = lamp_out[4];
  assign O_PORT_B_TRAFFIC_LAMP = lamp_out[5];
  assign O_PORT_A_LINK_LAMP_OE = run;
  assign O_PORT_A_RATE_LAMP_OE = run;
  assign O_PORT_A_TRAFFIC_LAMP_OE = run;
  assign O_PORT_B_LINK_LAMP_OE = run;
  assign O_PORT_B_RATE_LAMP_OE = run;
  assign O_PORT_B_TRAFFIC_LAMP_OE = run;
  // Open drain: only ever drives low.
  assign O_PORT_A_SLEEP_IRQ_PIN = 1'b0;
  assign O_PORT_B_SLEEP_IRQ_PIN = 1'b0;
  assign O_PORT_A_SLEEP_IRQ_PIN_OE = sleep_pin_oe[0];
  assign O_PORT_B_SLEEP_IRQ_PIN_OE = sleep_pin_oe[1];

endmodule // plrp_top

// >>> verification/plrp_top_properties.sv
// Checker bound to the lamp and sleep/interrupt pin block.
`timescale 1ns/1ps
module plrp_props (
  // Clock and reset.
  input logic I_SYS_CLK,
  input logic I_ARST_N,
  // Rate status and rate lamp pins.
  input logic [1:0] I_SPEED_100,
  input logic I_PORT_A_RATE_LAMP,
  input logic O_PORT_A_RATE_LAMP,
  input logic O_PORT_A_RATE_LAMP_OE,
  input logic I_PORT_B_RATE_LAMP,
  input logic O_PORT_B_RATE_LAMP,
  input logic O_PORT_B_RATE_LAMP_OE,
  // Port A shared pin, power-down and interrupt.
  input logic I_PORT_A_SLEEP_IRQ_PIN,
  input logic O_PORT_A_SLEEP_IRQ_PIN,
  input logic O_PORT_A_SLEEP_IRQ_PIN_OE,
  input logic [1:0] O_POWER_DOWN,
  input logic O_IRQ
);
  // ==========================================================
  // Helper logic
  // Edges since reset release; saturates so it never wraps.
  logic [5:0] since_rst;
  // Pull level of each rate pin, taken while the pin is released.
  logic pull_a;
  logic pull_b;
  always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      since_rst <= 6'h00;
    end else if (since_rst != 6'h3f) begin
      since_rst <= since_rst + 6'h01;
    end
  end
  // A released pin shows only its pull, so this is the polarity.
  always_ff @(posedge I_SYS_CLK) begin
    if (!O_PORT_A_RATE_LAMP_OE) begin
      pull_a <= I_PORT_A_RATE_LAMP;
    end
    if (!O_PORT_B_RATE_LAMP_OE) begin
      pull_b <= I_PORT_B_RATE_LAMP;
    end
  end
  // ==========================================================
  // Properties
  default clocking cb @(posedge I_SYS_CLK);
  endclocking
  default disable iff (!I_ARST_N);
  // Host holds the pin low while the device leaves it alone.
  sequence s_pin_low;
    !I_PORT_A_SLEEP_IRQ_PIN [*4];
  endsequence
  sequence s_no_drive;
    !O_PORT_A_SLEEP_IRQ_PIN_OE [*4];
  endsequence
  rate_lamp_a_a: assert property (O_PORT_A_RATE_LAMP_OE |->
    O_PORT_A_RATE_LAMP == (I_SPEED_100[0] ^ pull_a))
    else $error("port A rate lamp level wrong");
  rate_lamp_b_a: assert property (O_PORT_B_RATE_LAMP_OE |->
    O_PORT_B_RATE_LAMP == (I_SPEED_100[1] ^ pull_b))
    else $error("port B rate lamp level wrong");
  strap_window_a: assert property (since_rst < 6'd25 |->
    !O_PORT_A_RATE_LAMP_OE && !O_PORT_B_RATE_LAMP_OE)
    else $error("lamp driven inside strap window");
  lamp_enable_a: assert property (since_rst == 6'd25 |->
    O_PORT_A_RATE_LAMP_OE && O_PORT_B_RATE_LAMP_OE)
    else $error("lamp not driven after strap window");
  irq_drive_a: assert property (O_PORT_A_SLEEP_IRQ_PIN_OE |->
    O_IRQ && !O_PORT_A_SLEEP_IRQ_PIN && !O_POWER_DOWN[0])
    else $error("interrupt pin driven without cause");
  sleep_entry_a: assert property ($rose(O_POWER_DOWN[0]) |->
    !$past(I_PORT_A_SLEEP_IRQ_PIN, 3))
    else $error("power-down without a low pin");
  sleep_hold_a: assert property (s_pin_low and s_no_drive |->
    O_POWER_DOWN[0])
    else $error("low pin gave no power-down");
  reset_clear_a: assert property ($rose(I_ARST_N) |->
    O_POWER_DOWN == 2'b00 && !O_IRQ && !O_PORT_A_SLEEP_IRQ_PIN_OE)
    else $error("outputs not cleared by reset");
endmodule // plrp_props

bind plrp_top plrp_props u_props (
  .I_SYS_CLK(I_SYS_CLK), .I_ARST_N(I_ARST_N),
  .I_SPEED_100(I_SPEED_100), .I_PORT_A_RATE_LAMP(I_PORT_A_RATE_LAMP),
  .O_PORT_A_RATE_LAMP(O_PORT_A_RATE_LAMP),
  .O_PORT_A_RATE_LAMP_OE(O_PORT_A_RATE_LAMP_OE),
  .I_PORT_B_RATE_LAMP(I_PORT_B_RATE_LAMP),
  .O_PORT_B_RATE_LAMP(O_PORT_B_RATE_LAMP),
  .O_PORT_B_RATE_LAMP_OE(O_PORT_B_RATE_LAMP_OE),
  .I_PORT_A_SLEEP_IRQ_PIN(I_PORT_A_SLEEP_IRQ_PIN),
  .O_PORT_A_SLEEP_IRQ_PIN(O_PORT_A_SLEEP_IRQ_PIN),
  .O_PORT_A_SLEEP_IRQ_PIN_OE(O_PORT_A_SLEEP_IRQ_PIN_OE),
  .O_POWER_DOWN(O_POWER_DOWN), .O_IRQ(O_IRQ));

// >>> verification/plrp_pins.sv
// Lamp pull resistors and host side of the shared sleep/interrupt pins.
`timescale 1ns/1ps
module plrp_pins (
  // Strap pull, drive level and enable of each lamp pin.
  input logic [5:0] i_pull,
  input logic [5:0] i_lamp,
  input logic [5:0] i_lamp_oe,
  // Host sleep requests and device pull-down enables.
  input logic [1:0] i_host_low,
  input logic [1:0] i_pin_oe,
  // Wire levels fed back to the device.
  output logic [5:0] o_lamp_wire,
  output logic [1:0] o_pin_wire
);
  // A released lamp pin rests at its pull, which sets the polarity.
  assign o_lamp_wire = (i_lamp_oe & i_lamp) | (~i_lamp_oe & i_pull);
  // Pulled up; either party may pull it low, so it is a wired AND.
  assign o_pin_wire = ~(i_host_low | i_pin_oe);
endmodule // plrp_pins

// >>> verification/plrp_top_tb.sv
// Self-checking bench for the two-port lamp and sleep/interrupt pins.
`timescale 1ns/1ps
`include "plrp_defines.vh"
module plrp_top_tb;
  // Short blink so a run shows both phases.
  localparam int HALF = 4;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  wire [31:0] rdata;
  // Core status, strap, pulls and host side.
  logic [1:0] link = 2'h0, spd = 2'h0, fdx = 2'h0;
  logic [1:0] tx = 2'h0, rx = 2'h0, col = 2'h0, host_low = 2'h0;
  logic strap = 1'b1;
  logic [5:0] pull = 6'h00;
  // Lamp bits: 0 A link, 1 A rate, 2 A traffic, 3 to 5 port B.
  wire [5:0] lamp, lamp_oe, lamp_w;
  wire [1:0] pin_oe, pin_o, pin_w, pd;
  wire irq;
  // Model of the control register.
  logic [5:0] ctrl_m = 6'h00;
  int seed = 66255;
  int fail_count = 0;
  int checked = 0;
  int n;

  always #20 clk = ~clk;

  plrp_top #(.BLINK_HALF_CYC(HALF)) dut (
    .I_SYS_CLK(clk), .I_ARST_N(arst_n), .I_ADDR(addr),
    .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata),
    .I_LINK_GOOD(link), .I_SPEED_100(spd), .I_FULL_DUPLEX(fdx),
    .I_TX_ACTIVE(tx), .I_RX_ACTIVE(rx), .I_COLLISION(col),
    .I_LED_CFG_STRAP(strap),
    .I_PORT_A_LINK_LAMP(lamp_w[0]), .O_PORT_A_LINK_LAMP(lamp[0]),
    .O_PORT_A_LINK_LAMP_OE(lamp_oe[0]),
    .I_PORT_A_RATE_LAMP(lamp_w[1]), .O_PORT_A_RATE_LAMP(lamp[1]),
    .O_PORT_A_RATE_LAMP_OE(lamp_oe[1]),
    .I_PORT_A_TRAFFIC_LAMP(lamp_w[2]), .O_PORT_A_TRAFFIC_LAMP(lamp[2]),
    .O_PORT_A_TRAFFIC_LAMP_OE(lamp_oe[2]),
    .I_PORT_B_LINK_LAMP(lamp_w[3]), .O_PORT_B_LINK_LAMP(lamp[3]),
    .O_PORT_B_LINK_LAMP_OE(lamp_oe[3]),
    .I_PORT_B_RATE_LAMP(lamp_w[4]), .O_PORT_B_RATE_LAMP(lamp[4]),
    .O_PORT_B_RATE_LAMP_OE(lamp_oe[4]),
    .I_PORT_B_TRAFFIC_LAMP(lamp_w[5]), .O_PORT_B_TRAFFIC_LAMP(lamp[5]),
    .O_PORT_B_TRAFFIC_LAMP_OE(lamp_oe[5]),
    .I_PORT_A_SLEEP_IRQ_PIN(pin_w[0]), .O_PORT_A_SLEEP_IRQ_PIN(pin_o[0]),
    .O_PORT_A_SLEEP_IRQ_PIN_OE(pin_oe[0]),
    .I_PORT_B_SLEEP_IRQ_PIN(pin_w[1]), .O_PORT_B_SLEEP_IRQ_PIN(pin_o[1]),
    .O_PORT_B_SLEEP_IRQ_PIN_OE(pin_oe[1]),
    .O_POWER_DOWN(pd), .O_IRQ(irq));

  plrp_pins far (.i_pull(pull), .i_lamp(lamp), .i_lamp_oe(lamp_oe),
    .i_host_low(host_low), .i_pin_oe(pin_oe), .o_lamp_wire(lamp_w),
    .o_pin_wire(pin_w));

  // Compare one value; four-state so an unknown never matches.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("checked=%0d fail_count=%0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // One-cycle write strobe.
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe.
  task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, e);
  endtask

  // Lamp model; a blinking link lamp has no fixed level, so skip it.
  task automatic chk_lamps();
    logic two;
    logic act;
    logic lit;
    int p;
    #1;
    for (p = 0; p < 2; p++) begin
      two = ctrl_m[p] | !strap;
      act = tx[p] | rx[p];
      lit = two ? ((ctrl_m[p] & ctrl_m[p+2]) ? fdx[p] : col[p]) : act;
      if (!(two & act & link[p]))
        chk(lamp[3*p], link[p] ^ pull[3*p]);
      chk(lamp[3*p+1], spd[p] ^ pull[3*p+1]);
      chk(lamp[3*p+2], lit ^ pull[3*p+2]);
    end
    chk(lamp_oe, 6'h3f);
  endtask

  // Every mode 3 and duplex setting of both ports against random status.
  task automatic sweep();
    int c;
    for (c = 0; c < 16; c++) begin
      ctrl_m = 6'(c);
      wr_reg(`PLRP_ADDR_CTRL, 32'(c));
      repeat (4) begin
        @(posedge clk);
        {link, spd, fdx, tx, rx, col} <= 12'($random(seed));
        chk_lamps();
      end
    end
  endtask

  // Reset with new straps; the wait for the lamps is bounded.
  task automatic do_reset(input logic s, input int cyc);
    int k;
    arst_n <= 1'b0;
    strap <= s;
    pull <= 6'($random(seed));
    {link, spd, fdx, tx, rx, col} <= 12'h000;
    ctrl_m = 6'h00;
    repeat (cyc) @(posedge clk);
    arst_n <= 1'b1;
    for (k = 0; k < 40 && lamp_oe !== 6'h3f; k++) @(posedge clk);
    if (k == 40) begin
      fail_count++;
      end_of_test();
    end
    rd_chk(`PLRP_ADDR_STATUS, {26'h0, 1'b1, 4'h0, s});
    rd_chk(`PLRP_ADDR_CTRL, 32'h0);
    rd_chk(`PLRP_ADDR_IRQ_MASK, 32'h0);
    rd_chk(`PLRP_ADDR_IRQ_STAT, 32'h0);
    chk({pd, pin_oe}, 4'h0);
    $display("test reset done");
  endtask

  initial begin
    do_reset(1'b1, 6);
    // Default pin function is the sleep input, port A only.
    @(posedge clk);
    host_low <= 2'b01;
    repeat (3) @(posedge clk);
    #1 chk(pd, 2'b01);
    rd_chk(`PLRP_ADDR_STATUS, 32'h23);
    // Hand the request over to port B alone.
    @(posedge clk);
    host_low <= 2'b10;
    repeat (3) @(posedge clk);
    #1 chk(pd, 2'b10);
    @(posedge clk);
    host_low <= 2'b00;
    repeat (3) @(posedge clk);
    #1 chk(pd, 2'b00);
    $display("test sleep done");
    // Link events on both ports, only port A unmasked.
    wr_reg(`PLRP_ADDR_IRQ_MASK, 32'h1);
    @(posedge clk);
    link <= 2'b11;
    repeat (3) @(posedge clk);
    rd_chk(`PLRP_ADDR_IRQ_STAT, 32'h09);
    chk(irq, 1'b1);
    ctrl_m = 6'h10;
    wr_reg(`PLRP_ADDR_CTRL, 32'h10);
    @(posedge clk);
    #1 chk({pin_w, pin_oe, pd}, 6'b100100);
    wr_reg(`PLRP_ADDR_IRQ_STAT, 32'h1);
    #1 chk({irq, pin_oe}, 3'b000);
    rd_chk(`PLRP_ADDR_IRQ_STAT, 32'h08);
    wr_reg(4'h2, 32'hffffffff);
    rd_chk(4'h2, 32'h0);
    rd_chk(`PLRP_ADDR_CTRL, 32'h10);
    // Port B in interrupt function, raised by speed and duplex events.
    ctrl_m = 6'h30;
    wr_reg(`PLRP_ADDR_CTRL, 32'h30);
    wr_reg(`PLRP_ADDR_IRQ_MASK, 32'h30);
    spd <= 2'b10;
    fdx <= 2'b10;
    repeat (2) @(posedge clk);
    rd_chk(`PLRP_ADDR_IRQ_STAT, 32'h38);
    chk({irq, pin_o, pin_oe, pin_w}, 7'b1001001);
    $display("test interrupt done");
    sweep();
    $display("test mode one done");
    do_reset(1'b0, 25);
    sweep();
    $display("test mode two done");
    // Blink: half the cycles of a full period are dark.
    ctrl_m = 6'h00;
    wr_reg(`PLRP_ADDR_CTRL, 32'h0);
    {link, spd, fdx, tx, rx, col} <= 12'h410;
    repeat (2) @(posedge clk);
    n = 0;
    repeat (4 * HALF) begin
      @(posedge clk);
      #1 n += (lamp[0] ^ pull[0]) ? 0 : 1;
    end
    chk(32'(n), 32'(2 * HALF));
    $display("test blink done");
    end_of_test();
  end
endmodule // plrp_top_tb
